//--- logic/rmx_params.svh
// Purpose: offsets, reserved mask, field codes and reset values for the reference mux and output regs
// Assumes: 16-bit registers addressed by index over the device's own register port
// Notes:   definitions only
`ifndef RMX_PARAMS_SVH
`define RMX_PARAMS_SVH
`define RMX_ADDR_W          8
`define RMX_OFS_REF_CTRL    8'h04
`define RMX_OFS_OUT01_CTRL  8'h05
`define RMX_RST_REF_CTRL    16'h0000
`define RMX_RST_OUT01_CTRL  16'h0000
`define RMX_OUT01_RSVD_MASK 16'hfe00
`define RMX_SHAPE_OFF       2'h0
`define RMX_EN_DISABLE      2'h0
`define RMX_EN_ENABLE       2'h1
`define RMX_EN_STATIC0      2'h2
`define RMX_EN_STATIC1      2'h3
`endif

//--- logic/rmx_pkg.sv
// Purpose: types for the reference mux and output pair configuration block
// Assumes: field layouts follow the register map
// Notes:   no constants here, see rmx_params.svh
package rmx_pkg;
    typedef enum logic [1:0] {RMX_BUF_CML, RMX_BUF_LVDS, RMX_BUF_LVCMOS, RMX_BUF_XTAL} rmx_buf_t;
    typedef enum logic [1:0] {RMX_DRV_LVDS, RMX_DRV_CML, RMX_DRV_PECL} rmx_drv_t;

    typedef struct packed {
        logic [1:0] refmux_shaping_select;
        logic       refmux_auto_manual;
        logic       refmux_source_choice;
        logic [3:0] primary_input_divider;
        logic [1:0] secondary_buffer_type;
        logic       secondary_input_enable;
        logic [1:0] primary_buffer_type;
        logic       primary_input_enable;
        logic       secondary_supply_level;
        logic       primary_supply_level;
    } rmx_ref_ctrl_t;

    typedef struct packed {
        logic [6:0] reserved;
        logic [1:0] out1_driver_type;
        logic [1:0] out1_enable_mode;
        logic [1:0] out0_driver_type;
        logic [1:0] out0_enable_mode;
        logic       out01_supply_level;
    } rmx_out01_ctrl_t;

    typedef struct packed {
        logic       clock_delay_en;
        logic       clock_reshape_en;
        logic       manual_mode;
        logic       use_secondary;
        logic [4:0] divide_ratio;
        rmx_buf_t   secondary_buffer;
        logic       secondary_on;
        rmx_buf_t   primary_buffer;
        logic       primary_on;
        logic       secondary_high_supply;
        logic       primary_high_supply;
    } rmx_ref_cfg_t;

    typedef struct packed {
        logic     driving;
        logic     static_level;
        logic     static_hold;
        rmx_drv_t driver;
    } rmx_chan_cfg_t;
endpackage : rmx_pkg

//--- logic/rmx_chan_decode.sv
// Purpose: decode one output channel's driver type and enable mode
// Assumes: fields come straight from the output pair control register
// Notes:   purely combinational
`timescale 1ns/1ps
`include "rmx_params.svh"
module rmx_chan_decode (
    // register fields
    input  wire logic [1:0]           driver_type,
    input  wire logic [1:0]           enable_mode,
    input  wire logic                 held,
    // decoded channel
    output rmx_pkg::rmx_chan_cfg_t    chan
);
    wire rmx_pkg::rmx_drv_t drv_sel = (driver_type == 2'h3) ? rmx_pkg::RMX_DRV_PECL :
                                      (driver_type == 2'h2) ? rmx_pkg::RMX_DRV_CML :
                                                              rmx_pkg::RMX_DRV_LVDS;
    wire drv_on  = !held && (enable_mode == `RMX_EN_ENABLE);
    wire st_hold = !held && (enable_mode == `RMX_EN_STATIC0 || enable_mode == `RMX_EN_STATIC1);
    assign chan.driving      = drv_on;
    assign chan.static_hold  = st_hold;
    assign chan.static_level = st_hold && (enable_mode == `RMX_EN_STATIC1);
    assign chan.driver       = drv_sel;
endmodule : rmx_chan_decode

//--- logic/rmx_config_regs.sv
// Purpose: reference input and output pair 0/1 configuration registers
// Assumes: register port strobes are synchronous to clk, one access per strobe
// Notes:   reads are registered, data valid one cycle after the read strobe
`timescale 1ns/1ps
`include "rmx_params.svh"
module rmx_config_regs (
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   nrst,
    // register port
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    input  wire logic [`RMX_ADDR_W-1:0] reg_addr,
    input  wire logic [15:0]            reg_wdata,
    output logic      [15:0]            reg_rdata,
    output logic                        reg_rvalid,
    // device state
    input  wire logic                   pin_mode,
    input  wire logic                   ref_select_pin,
    input  wire logic                   device_run_control,
    // decoded configuration
    output rmx_pkg::rmx_ref_cfg_t       ref_cfg,
    output rmx_pkg::rmx_chan_cfg_t      out0_cfg,
    output rmx_pkg::rmx_chan_cfg_t      out1_cfg,
    output logic                        out01_high_supply,
    output logic                        device_held
);
    rmx_pkg::rmx_ref_ctrl_t   ref_q,   ref_d;
    rmx_pkg::rmx_out01_ctrl_t out_q,   out_d;
    logic [15:0]              rdata_q, rdata_d;
    logic                     rvalid_q;

    function automatic rmx_pkg::rmx_buf_t buf_decode(input logic [1:0] code, input logic xtal_ok);
        rmx_pkg::rmx_buf_t b;
        b = rmx_pkg::rmx_buf_t'(code);
        if (code == 2'h3 && !xtal_ok) begin
            b = rmx_pkg::RMX_BUF_LVCMOS;
        end
        return b;
    endfunction : buf_decode

    wire sel_ref = (reg_addr == `RMX_OFS_REF_CTRL);
    wire sel_out = (reg_addr == `RMX_OFS_OUT01_CTRL);
    wire wr_ref  = reg_wr && sel_ref;
    wire wr_out  = reg_wr && sel_out;

    assign ref_d   = wr_ref ? rmx_pkg::rmx_ref_ctrl_t'(reg_wdata) : ref_q;
    assign out_d   = wr_out ? rmx_pkg::rmx_out01_ctrl_t'(reg_wdata) : out_q;
    assign rdata_d = !reg_rd ? rdata_q :
                     sel_ref ? 16'(ref_q) :
                     sel_out ? 16'(out_q) : 16'h0000;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            ref_q    <= `RMX_RST_REF_CTRL;
            out_q    <= `RMX_RST_OUT01_CTRL;
            rdata_q  <= 16'h0000;
            rvalid_q <= 1'b0;
        end else begin
            ref_q    <= ref_d;
            out_q    <= out_d;
            rdata_q  <= rdata_d;
            rvalid_q <= reg_rd;
        end
    end

    assign reg_rdata  = rdata_q;
    assign reg_rvalid = rvalid_q;

    assign device_held = !device_run_control;

    wire [1:0] shape = pin_mode ? `RMX_SHAPE_OFF : ref_q.refmux_shaping_select;
    assign ref_cfg.clock_delay_en   = !device_held && shape[0];
    assign ref_cfg.clock_reshape_en = !device_held && shape[1];
    assign ref_cfg.manual_mode      = ref_q.refmux_auto_manual;
    assign ref_cfg.use_secondary    = ref_q.refmux_auto_manual && ref_q.refmux_source_choice
                                      && ref_select_pin;
    assign ref_cfg.divide_ratio     = {1'b0, ref_q.primary_input_divider} + 5'h01;
    assign ref_cfg.secondary_buffer = buf_decode(ref_q.secondary_buffer_type, 1'b1);
    assign ref_cfg.secondary_on     = !device_held && ref_q.secondary_input_enable;
    assign ref_cfg.primary_buffer   = buf_decode(ref_q.primary_buffer_type, 1'b0);
    assign ref_cfg.primary_on       = !device_held && ref_q.primary_input_enable;
    assign ref_cfg.secondary_high_supply = ref_q.secondary_supply_level;
    assign ref_cfg.primary_high_supply   = ref_q.primary_supply_level;
    assign out01_high_supply = out_q.out01_supply_level;

    rmx_chan_decode u_ch0 (
        .driver_type (out_q.out0_driver_type),
        .enable_mode (out_q.out0_enable_mode),
        .held        (device_held),
        .chan        (out0_cfg)
    );
    rmx_chan_decode u_ch1 (
        .driver_type (out_q.out1_driver_type),
        .enable_mode (out_q.out1_enable_mode),
        .held        (device_held),
        .chan        (out1_cfg)
    );

    chk_reg_readback: assert property (@(posedge clk) disable iff (!nrst)
        nrst && wr_ref ##1 !reg_wr ##1 reg_rd && sel_ref && !reg_wr
        |=> reg_rdata == $past(reg_wdata, 3))
        else $error("readback mismatch");
    chk_reg_hold: assert property (@(posedge clk) disable iff (!nrst)
        nrst && !wr_out |=> out_q == $past(out_q))
        else $error("register changed without write");
    chk_pin_shape: assert property (@(posedge clk) disable iff (!nrst)
        pin_mode |-> !ref_cfg.clock_delay_en && !ref_cfg.clock_reshape_en)
        else $error("shaping active in pin mode");
    chk_auto_primary: assert property (@(posedge clk) disable iff (!nrst)
        !ref_q.refmux_auto_manual |-> !ref_cfg.use_secondary)
        else $error("secondary chosen in auto");
    chk_pin_gate: assert property (@(posedge clk) disable iff (!nrst)
        ref_cfg.use_secondary |-> ref_select_pin && ref_q.refmux_source_choice)
        else $error("secondary without pin");
    chk_div_ratio: assert property (@(posedge clk) disable iff (!nrst)
        nrst && wr_ref |=> ref_cfg.divide_ratio == {1'b0, $past(reg_wdata[11:8])} + 5'h01)
        else $error("divider ratio wrong");
    chk_static_lvl: assert property (@(posedge clk) disable iff (!nrst)
        wr_out && device_run_control && reg_wdata[2:1] == 2'h3 ##1 device_run_control
        |-> out0_cfg.static_hold && out0_cfg.static_level && !out0_cfg.driving)
        else $error("static level wrong");
    chk_held_off: assert property (@(posedge clk) disable iff (!nrst)
        device_held |-> !out0_cfg.driving && !out1_cfg.driving && !ref_cfg.primary_on)
        else $error("active while held");
    chk_drv_pecl: assert property (@(posedge clk) disable iff (!nrst)
        wr_out && reg_wdata[8:7] == 2'h3 |=> out1_cfg.driver == rmx_pkg::RMX_DRV_PECL)
        else $error("driver decode wrong");
    chk_rvalid_next: assert property (@(posedge clk) disable iff (!nrst)
        nrst && reg_rd |=> reg_rvalid)
        else $error("read not answered");
    chk_rvalid_pulse: assert property (@(posedge clk) disable iff (!nrst)
        !reg_rd |=> !reg_rvalid)
        else $error("answer without read");
    chk_unmapped_zero: assert property (@(posedge clk) disable iff (!nrst)
        nrst && reg_rd && !sel_ref && !sel_out |=> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    chk_unmapped_keep: assert property (@(posedge clk) disable iff (!nrst)
        nrst && reg_wr && !sel_ref && !sel_out
        |=> ref_q == $past(ref_q) && out_q == $past(out_q))
        else $error("unmapped write stored");
    chk_shape_delay: assert property (@(posedge clk) disable iff (!nrst)
        !pin_mode && !device_held && ref_q.refmux_shaping_select == 2'h1
        |-> ref_cfg.clock_delay_en && !ref_cfg.clock_reshape_en)
        else $error("delay only code wrong");
    chk_shape_reshape: assert property (@(posedge clk) disable iff (!nrst)
        !pin_mode && !device_held && ref_q.refmux_shaping_select == 2'h2
        |-> !ref_cfg.clock_delay_en && ref_cfg.clock_reshape_en)
        else $error("reshape only code wrong");
    chk_sec_xtal: assert property (@(posedge clk) disable iff (!nrst)
        ref_q.secondary_buffer_type == 2'h3
        |-> ref_cfg.secondary_buffer == rmx_pkg::RMX_BUF_XTAL)
        else $error("secondary crystal decode wrong");
    chk_pri_lvcmos: assert property (@(posedge clk) disable iff (!nrst)
        ref_q.primary_buffer_type == 2'h3
        |-> ref_cfg.primary_buffer == rmx_pkg::RMX_BUF_LVCMOS)
        else $error("primary buffer decode wrong");
    chk_out_supply: assert property (@(posedge clk) disable iff (!nrst)
        nrst && wr_out |=> out01_high_supply == $past(reg_wdata[0]))
        else $error("output supply wrong");
    chk_in_supply: assert property (@(posedge clk) disable iff (!nrst)
        nrst && wr_ref |=> ref_cfg.secondary_high_supply == $past(reg_wdata[1])
        && ref_cfg.primary_high_supply == $past(reg_wdata[0]))
        else $error("input supply wrong");
    chk_mode_bit: assert property (@(posedge clk) disable iff (!nrst)
        nrst && wr_ref |=> ref_cfg.manual_mode == $past(reg_wdata[13]))
        else $error("mode bit wrong");
    chk_static_zero: assert property (@(posedge clk) disable iff (!nrst)
        wr_out && device_run_control && reg_wdata[6:5] == 2'h2 ##1 device_run_control
        |-> out1_cfg.static_hold && !out1_cfg.static_level && !out1_cfg.driving)
        else $error("static zero wrong");

    cov_manual_sec: cover property (@(posedge clk) ref_cfg.use_secondary);
    cov_both_shape: cover property (@(posedge clk)
        ref_cfg.clock_delay_en && ref_cfg.clock_reshape_en);
    cov_held: cover property (@(posedge clk) device_held ##1 !device_held);
    cov_pin_forced: cover property (@(posedge clk)
        pin_mode && ref_q.refmux_shaping_select != 2'h0);
    cov_unmapped_rd: cover property (@(posedge clk) reg_rd && !sel_ref && !sel_out);
endmodule : rmx_config_regs

//--- sim/rmx_host_model.sv
// Purpose: host model driving the register port
// Assumes: answer to a read one cycle after the strobe
// Notes:   tasks called by the bench
`timescale 1ns/1ps
`include "rmx_params.svh"
module rmx_host_model (
    // clock
    input  wire logic                   clk,
    // register port
    output logic                        reg_wr,
    output logic                        reg_rd,
    output logic      [`RMX_ADDR_W-1:0] reg_addr,
    output logic      [15:0]            reg_wdata,
    input  wire logic [15:0]            reg_rdata,
    input  wire logic                   reg_rvalid
);
    initial begin
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = 8'hff;
        reg_wdata = 16'h0000;
    end

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [15:0] v;
        v = d;
        if (a == `RMX_OFS_OUT01_CTRL)
            v = v & ~`RMX_OUT01_RSVD_MASK;
        if (a == `RMX_OFS_REF_CTRL && !v[13])
            v = v | 16'h0024;
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr    <= 1'b0;
        reg_addr  <= ~a;
        reg_wdata <= ~v;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic v, output logic [15:0] d);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd   <= 1'b0;
        reg_addr <= ~a;
        #1;
        v = reg_rvalid;
        d = reg_rdata;
    endtask : rd
endmodule : rmx_host_model

//--- sim/rmx_config_regs_tb.sv
// Purpose: self-checking bench for the configuration registers
// Assumes: host model drives the register port
// Notes:   reset reads first, then rows, then unmapped, write-then-read and re-reset cases
`timescale 1ns/1ps
`include "rmx_params.svh"
module rmx_config_regs_tb;
    typedef struct packed {
        logic [15:0] w4;
        logic [15:0] w5;
        logic        pin;
        logic        sel;
        logic        run;
    } rmx_row_t;

    logic                   clk = 1'b0;
    logic                   nrst;
    logic                   reg_wr;
    logic                   reg_rd;
    logic [7:0]             reg_addr;
    logic [15:0]            reg_wdata;
    logic [15:0]            reg_rdata;
    logic                   reg_rvalid;
    logic                   pin_mode;
    logic                   ref_select_pin;
    logic                   device_run_control;
    rmx_pkg::rmx_ref_cfg_t  ref_cfg;
    rmx_pkg::rmx_chan_cfg_t out0_cfg;
    rmx_pkg::rmx_chan_cfg_t out1_cfg;
    logic                   out01_high_supply;
    logic                   device_held;
    logic                   v;
    logic [15:0]            d;
    int                     errors = 0;
    int                     samples_checked = 0;
    rmx_row_t               rows [6] = '{
        '{16'h3fff, 16'h01ff, 1'b0, 1'b1, 1'b1}, '{16'h5024, 16'h0000, 1'b0, 1'b1, 1'b1},
        '{16'hb0d9, 16'h0152, 1'b0, 1'b0, 1'b1}, '{16'hc5ac, 16'h01e7, 1'b1, 1'b0, 1'b1},
        '{16'hf3ff, 16'h0063, 1'b0, 1'b0, 1'b0}, '{16'hc074, 16'h0088, 1'b0, 1'b0, 1'b1}};

    always #2 clk = ~clk;

    rmx_config_regs i_rmx_config_regs (.clk(clk), .nrst(nrst), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .pin_mode(pin_mode), .ref_select_pin(ref_select_pin),
        .device_run_control(device_run_control), .ref_cfg(ref_cfg), .out0_cfg(out0_cfg),
        .out1_cfg(out1_cfg), .out01_high_supply(out01_high_supply),
        .device_held(device_held));
    rmx_host_model i_rmx_host_model (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid));

    function automatic rmx_pkg::rmx_chan_cfg_t exp_ch(input logic [1:0] t, input logic [1:0] e,
                                                      input logic r);
        rmx_pkg::rmx_chan_cfg_t c;
        c.driving      = (e == 2'h1) && r;
        c.static_level = (e == 2'h3) && r;
        c.static_hold  = e[1] && r;
        c.driver       = !t[1] ? rmx_pkg::RMX_DRV_LVDS
                       : (t[0] ? rmx_pkg::RMX_DRV_PECL : rmx_pkg::RMX_DRV_CML);
        return c;
    endfunction : exp_ch

    function automatic rmx_pkg::rmx_ref_cfg_t exp_ref(input rmx_row_t r);
        rmx_pkg::rmx_ref_cfg_t c;
        c.clock_delay_en        = r.w4[14] && r.run && !r.pin;
        c.clock_reshape_en      = r.w4[15] && r.run && !r.pin;
        c.manual_mode           = r.w4[13];
        c.use_secondary         = r.w4[13] && r.w4[12] && r.sel;
        c.divide_ratio          = {1'b0, r.w4[11:8]} + 5'h01;
        c.secondary_buffer      = rmx_pkg::rmx_buf_t'(r.w4[7:6]);
        c.secondary_on          = r.w4[5] && r.run;
        c.primary_buffer        = rmx_pkg::rmx_buf_t'({r.w4[4], r.w4[3] && !r.w4[4]});
        c.primary_on            = r.w4[2] && r.run;
        c.secondary_high_supply = r.w4[1];
        c.primary_high_supply   = r.w4[0];
        return c;
    endfunction : exp_ref

    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            errors++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    task automatic finish_test;
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : finish_test

    initial begin
        #20000;
        errors++;
        finish_test();
    end

    initial begin
        nrst               = 1'b0;
        pin_mode           = 1'b0;
        ref_select_pin     = 1'b0;
        device_run_control = 1'b1;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        i_rmx_host_model.rd(`RMX_OFS_REF_CTRL, v, d);
        chk("reset ref", {v, d}, {1'b1, `RMX_RST_REF_CTRL});
        i_rmx_host_model.rd(`RMX_OFS_OUT01_CTRL, v, d);
        chk("reset out", {v, d}, {1'b1, `RMX_RST_OUT01_CTRL});
        foreach (rows[i]) begin
            @(posedge clk);
            pin_mode           <= rows[i].pin;
            ref_select_pin     <= rows[i].sel;
            device_run_control <= rows[i].run;
            i_rmx_host_model.wr(`RMX_OFS_REF_CTRL, rows[i].w4);
            i_rmx_host_model.wr(`RMX_OFS_OUT01_CTRL, rows[i].w5);
            i_rmx_host_model.rd(`RMX_OFS_REF_CTRL, v, d);
            chk("ref rd", d, rows[i].w4);
            i_rmx_host_model.rd(`RMX_OFS_OUT01_CTRL, v, d);
            chk("out rd", d, rows[i].w5);
            chk("ref_cfg", ref_cfg, exp_ref(rows[i]));
            chk("out0", out0_cfg, exp_ch(rows[i].w5[4:3], rows[i].w5[2:1], rows[i].run));
            chk("out1", out1_cfg, exp_ch(rows[i].w5[8:7], rows[i].w5[6:5], rows[i].run));
            chk("supply", out01_high_supply, rows[i].w5[0]);
            chk("held", device_held, !rows[i].run);
        end
        i_rmx_host_model.wr(8'h06, 16'h1234);
        i_rmx_host_model.rd(8'h06, v, d);
        chk("unmapped", {v, d}, 17'h10000);
        @(posedge clk);
        #1;
        chk("rvalid pulse", reg_rvalid, 1'b0);
        i_rmx_host_model.rd(`RMX_OFS_OUT01_CTRL, v, d);
        chk("kept", d, rows[5].w5);
        i_rmx_host_model.wr(`RMX_OFS_REF_CTRL, 16'h2a5b);
        i_rmx_host_model.rd(`RMX_OFS_REF_CTRL, v, d);
        chk("wr then rd", {v, d}, {1'b1, 16'h2a5b});
        @(posedge clk);
        nrst <= 1'b0;
        @(posedge clk);
        nrst <= 1'b1;
        i_rmx_host_model.rd(`RMX_OFS_REF_CTRL, v, d);
        chk("rereset", {v, d}, {1'b1, `RMX_RST_REF_CTRL});
        i_rmx_host_model.rd(`RMX_OFS_OUT01_CTRL, v, d);
        chk("rereset out", d, `RMX_RST_OUT01_CTRL);
        finish_test();
    end
endmodule : rmx_config_regs_tb
